// ### logic/gpib_regs_pkg.sv
// package: register numbers, field positions, reset values for the bus card register set
// assumes: registers are reached by a register number with separate read and write strobes
package gpib_regs_pkg;
  // register numbers as seen by status and control statements
  localparam logic [3:0] REG_CARD_ID     = 4'h0;
  localparam logic [3:0] REG_IF_RESET    = 4'h0;
  localparam logic [3:0] REG_INT_DMA     = 4'h1;
  localparam logic [3:0] REG_SERIAL_POLL = 4'h1;
  localparam logic [3:0] REG_ACTIVITY    = 4'h2;
  localparam logic [3:0] REG_PAR_POLL    = 4'h2;
  localparam logic [3:0] REG_CTRL_ADDR   = 4'h3;
  localparam logic [3:0] REG_OWN_ADDR    = 4'h3;
  localparam logic [3:0] REG_INT_CAUSE   = 4'h4;
  // identification value, arbitrary
  localparam logic [7:0] CARD_ID_VALUE   = 8'h5A;
  // field positions
  localparam int INTDMA_EN_BIT     = 7;
  localparam int INTDMA_REQ_BIT    = 6;
  localparam int INTDMA_LVL_LSB    = 4;
  localparam int SPOLL_SRQ_BIT     = 6;
  localparam int CTRL_SYS_BIT      = 7;
  localparam int CTRL_ACT_BIT      = 6;
  localparam int ACT_HS_BIT        = 2;
  localparam int ACT_IE_BIT        = 1;
  localparam int CAUSE_WIDTH       = 16;
  // reset values
  localparam logic [7:0] SPOLL_RESET = 8'h00;
  localparam logic [7:0] PPOLL_RESET = 8'h00;
  localparam logic [4:0] ADDR_RESET  = 5'h00;
endpackage

// ### logic/cause_flags.sv
// holds the sticky interrupt cause word
// assumes: events are single-cycle pulses on clk; clear comes from the register logic
module cause_flags (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // events and clear
  input  wire logic [15:0] evt,
  input  wire logic        clrAll,
  // flags
  output logic      [15:0] flags
);
  typedef struct packed {
    logic [15:0] flags;
  } state_s;
  state_s st_q;
  state_s st_d;

  // set wins over clear
  always_comb begin
    st_d = st_q;
    if (clrAll) begin
      st_d.flags = 16'h0000;
    end
    st_d.flags = st_d.flags | evt;
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;

  AST_FLAG_SETS: assert property (@(posedge clk) disable iff (srst)
    (evt[0] |=> flags[0])) else $error("cause flag not set");
endmodule

// ### logic/gpib_card_status_control_regs.sv
// register set of a parallel instrument bus card: status, control, poll bytes, cause word
// assumes: bus pins arrive raw and are synchronised here; register strobes are on clk
//
// Contract
// - The interrupt and DMA status byte shows enable, request, level and DMA enables.
// - The serial poll byte is returned in a serial poll and its bit 6 asserts SRQ.
// - Parallel poll byte bits 7..0 drive data lines 8..1 true during a parallel poll.
// - Controller byte shows system and active roles, a zero, then the five-bit address.
// - A service request keeps SRQ asserted until software clears the request bit or resets the interface.
// - ATN is driven true only while the interface is active controller.
module gpib_card_status_control_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // register access
  input  wire logic [3:0]  regNum,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [7:0]  wrData,
  output logic      [15:0] rdData,
  // host side state
  input  wire logic        intEnable,
  input  wire logic [1:0]  intLevel,
  input  wire logic [1:0]  dmaEnable,
  input  wire logic        handshakeBusy,
  input  wire logic        sysController,
  input  wire logic        activeController,
  input  wire logic        atnRequest,
  // bus events, raw
  input  wire logic [15:0] busEvent,
  // bus polls, raw pins
  input  wire logic        serialPollPin,
  input  wire logic        parallelPollPin,
  // bus outputs
  output logic      [7:0]  dioOut,
  output logic      [7:0]  dioOe,
  output logic             srqOut,
  output logic             atnOut,
  output logic             ifReset,
  output logic             intRequest
);
  typedef struct packed {
    logic [7:0]  spoll;
    logic [7:0]  ppoll;
    logic [4:0]  addr;
    logic [1:0]  spSync;
    logic [1:0]  ppSync;
    logic [15:0] evS1;
    logic [15:0] evS2;
    logic [15:0] evPrev;
    logic [15:0] rd;
    logic        rst;
    logic [7:0]  dio;
    logic [7:0]  oe;
    logic        atn;
  } state_s;
  state_s st_q;
  state_s st_d;
  logic [15:0] cause;
  logic        causeClr;
  logic [15:0] evtPulse;

  // byte padded into a read word
  function automatic logic [15:0] rdByte(input logic [7:0] b);
    rdByte = {8'h00, b};
  endfunction

  assign evtPulse = st_q.evS2 & ~st_q.evPrev;
  assign causeClr = regRd && (regNum == gpib_regs_pkg::REG_INT_CAUSE);

  // sticky cause flags
  cause_flags uFlags (
    .clk    (clk),
    .srst   (srst | st_q.rst),
    .evt    (evtPulse),
    .clrAll (causeClr),
    .flags  (cause)
  );

  // next state: register writes, reads, poll responses
  always_comb begin
    st_d        = st_q;
    st_d.spSync = {st_q.spSync[0], serialPollPin};
    st_d.ppSync = {st_q.ppSync[0], parallelPollPin};
    st_d.evS1   = busEvent;
    st_d.evS2   = st_q.evS1;
    st_d.evPrev = st_q.evS2;
    st_d.rst    = 1'b0;
    if (regWr) begin
      case (regNum)
        gpib_regs_pkg::REG_IF_RESET:    st_d.rst = |wrData;
        gpib_regs_pkg::REG_SERIAL_POLL: st_d.spoll = wrData;
        gpib_regs_pkg::REG_PAR_POLL:    st_d.ppoll = wrData;
        gpib_regs_pkg::REG_OWN_ADDR:    st_d.addr = wrData[4:0];
        default:                        st_d.rst = 1'b0;
      endcase
    end
    st_d.rd = 16'h0000;
    if (regRd) begin
      case (regNum)
        gpib_regs_pkg::REG_CARD_ID: st_d.rd = rdByte(gpib_regs_pkg::CARD_ID_VALUE);
        gpib_regs_pkg::REG_INT_DMA:
          st_d.rd = rdByte({intEnable, |cause, intLevel, 2'b00, dmaEnable});
        gpib_regs_pkg::REG_ACTIVITY:
          st_d.rd = rdByte({5'h00, handshakeBusy, intEnable, 1'b0});
        gpib_regs_pkg::REG_CTRL_ADDR:
          st_d.rd = rdByte({sysController, activeController, 1'b0, st_q.addr});
        gpib_regs_pkg::REG_INT_CAUSE: st_d.rd = cause;
        default:                      st_d.rd = 16'h0000;
      endcase
    end
    // poll answers on data lines
    st_d.dio = 8'h00;
    st_d.oe  = 8'h00;
    if (st_q.ppSync[1]) begin
      st_d.dio = st_q.ppoll;
      st_d.oe  = st_q.ppoll;
    end else if (st_q.spSync[1]) begin
      st_d.dio = st_q.spoll;
      st_d.oe  = 8'hFF;
    end
    st_d.atn = atnRequest & activeController;
    if (st_q.rst) begin
      st_d.spoll = gpib_regs_pkg::SPOLL_RESET;
      st_d.ppoll = gpib_regs_pkg::PPOLL_RESET;
      st_d.addr  = gpib_regs_pkg::ADDR_RESET;
      st_d.dio   = 8'h00;
      st_d.oe    = 8'h00;
      st_d.atn   = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs
  assign rdData     = st_q.rd;
  assign dioOut     = st_q.dio;
  assign dioOe      = st_q.oe;
  assign srqOut     = st_q.spoll[gpib_regs_pkg::SPOLL_SRQ_BIT];
  assign atnOut     = st_q.atn;
  assign ifReset    = st_q.rst;
  assign intRequest = intEnable & (|cause);

  // interface reset is a two-step behaviour: the pulse, then the cleared state
  // a write of any set bit to the reset register
  sequence seqResetWrite;
    regWr && regNum == gpib_regs_pkg::REG_IF_RESET && wrData != 8'h00;
  endsequence
  // what the reset pulse leaves behind one cycle later
  sequence seqResetCleared;
    !srqOut && !atnOut && dioOe == 8'h00 && cause == 16'h0000;
  endsequence

  // register writes and the reset pulse
  AST_RESET_ON_WRITE: assert property (@(posedge clk) disable iff (srst)
    seqResetWrite |=> ifReset)
    else $error("reset write ignored");
  AST_RESET_CLEARS: assert property (@(posedge clk) disable iff (srst)
    seqResetWrite |=> ifReset ##1 seqResetCleared)
    else $error("interface reset left state behind");
  AST_RESET_SOURCE: assert property (@(posedge clk) disable iff (srst)
    !(regWr && regNum == gpib_regs_pkg::REG_IF_RESET) |=> !ifReset)
    else $error("reset pulse without reset write");
  AST_SRQ_FROM_BYTE: assert property (@(posedge clk) disable iff (srst)
    (regWr && regNum == gpib_regs_pkg::REG_SERIAL_POLL
      && wrData[gpib_regs_pkg::SPOLL_SRQ_BIT] && !ifReset) |=> srqOut)
    else $error("srq not asserted");
  AST_SRQ_HOLDS: assert property (@(posedge clk) disable iff (srst)
    (srqOut && !regWr && !ifReset) |=> srqOut)
    else $error("srq dropped");

  // read answers, checked against the levels at the strobe's edge
  AST_INTDMA_ZERO: assert property (@(posedge clk) disable iff (srst)
    (regRd && regNum == gpib_regs_pkg::REG_INT_DMA)
      |=> rdData[3:2] == 2'b00 && rdData[1:0] == $past(dmaEnable))
    else $error("dma status wrong");
  AST_INTDMA_FIELDS: assert property (@(posedge clk) disable iff (srst)
    (regRd && regNum == gpib_regs_pkg::REG_INT_DMA)
      |=> rdData[gpib_regs_pkg::INTDMA_EN_BIT] == $past(intEnable)
      && rdData[gpib_regs_pkg::INTDMA_REQ_BIT] == ($past(cause) != 16'h0000)
      && rdData[gpib_regs_pkg::INTDMA_LVL_LSB +: 2] == $past(intLevel)
      && rdData[15:8] == 8'h00)
    else $error("interrupt status fields wrong");
  AST_CTRL_READ: assert property (@(posedge clk) disable iff (srst)
    (regRd && regNum == gpib_regs_pkg::REG_CTRL_ADDR)
      |=> rdData[5] == 1'b0 && rdData[4:0] == $past(st_q.addr))
    else $error("controller byte wrong");
  AST_ROLE_READ: assert property (@(posedge clk) disable iff (srst)
    (regRd && regNum == gpib_regs_pkg::REG_CTRL_ADDR)
      |=> rdData[gpib_regs_pkg::CTRL_SYS_BIT] == $past(sysController)
      && rdData[gpib_regs_pkg::CTRL_ACT_BIT] == $past(activeController))
    else $error("controller roles wrong");

  // poll answers on the data lines
  AST_PPOLL_MAP: assert property (@(posedge clk) disable iff (srst)
    (st_q.ppSync[1] && !st_q.rst)
      |=> dioOut == $past(st_q.ppoll) && dioOe == $past(st_q.ppoll))
    else $error("parallel poll mismatch");
  AST_SPOLL_DRIVE: assert property (@(posedge clk) disable iff (srst)
    (st_q.spSync[1] && !st_q.ppSync[1] && !st_q.rst)
      |=> dioOut == $past(st_q.spoll) && dioOe == 8'hFF)
    else $error("serial poll mismatch");
  AST_LINES_IDLE: assert property (@(posedge clk) disable iff (srst)
    (!st_q.spSync[1] && !st_q.ppSync[1]) |=> dioOe == 8'h00)
    else $error("data lines driven outside a poll");

  // attention and the cause word
  AST_ATN_ROLE: assert property (@(posedge clk) disable iff (srst)
    atnOut |-> $past(activeController))
    else $error("atn without role");
  AST_CAUSE_SET: assert property (@(posedge clk) disable iff (srst || ifReset)
    (evtPulse[15] && !st_q.rst) |=> cause[15])
    else $error("cause flag missing");
  AST_CAUSE_CLEARED: assert property (@(posedge clk) disable iff (srst)
    (causeClr && evtPulse == 16'h0000) |=> cause == 16'h0000)
    else $error("cause word not cleared by read");
endmodule

// ### testbench/bus_controller_model.sv
// bus side model: a controller that runs polls and raises bus events
// assumes: bench commands change at falling clk; pins follow at rising clk
module bus_controller_model (
  // clock
  input  wire logic        clk,
  // commands from the bench
  input  wire logic [1:0]  pollCmd,
  input  wire logic [15:0] evtCmd,
  // bus side levels
  output logic             serialPollPin,
  output logic             parallelPollPin,
  output logic      [15:0] busEvent
);
  timeunit 1ns;
  timeprecision 1ns;
  // lines idle until the first command
  initial begin
    serialPollPin   = 1'b0;
    parallelPollPin = 1'b0;
    busEvent        = 16'h0000;
  end
  // poll lines and event levels follow the commands
  always @(posedge clk) begin
    serialPollPin   <= pollCmd[0];
    parallelPollPin <= pollCmd[1];
    busEvent        <= evtCmd;
  end
endmodule

// ### testbench/tb_gpib_card_status_control_regs.sv
// bench for the bus card register set: table of register cases, then hand tests
// assumes: design samples strobes on rising clk; bench drives at falling clk
module tb_gpib_card_status_control_regs;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0]  wn;
    logic [7:0]  wd;
    logic [7:0]  host;
    logic [3:0]  rn;
    logic [15:0] exp;
  } row_s;
  logic        clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, atnRequest = 1'b0;
  logic [3:0]  regNum = 4'h0;
  logic [7:0]  wrData = 8'h00, host = 8'h00, dioOut, dioOe;
  logic [1:0]  pollCmd = 2'h0;
  logic [15:0] evtCmd = 16'h0000, rdData, busEvent;
  logic        srqOut, atnOut, ifReset, intRequest, serialPollPin, parallelPollPin;
  int          error_cnt = 0, n_compared = 0;
  // write number, data, host levels, read number, expected read
  row_s        rows[6] = '{'{4'h3, 8'hE3, 8'h03, 4'h3, 16'h00C3},
    '{4'h3, 8'h1F, 8'h01, 4'h3, 16'h005F},
    '{4'hF, 8'hFF, 8'h00, 4'h0, {8'h00, gpib_regs_pkg::CARD_ID_VALUE}},
    '{4'hF, 8'h00, 8'hC8, 4'h1, 16'h00A1}, '{4'hF, 8'h00, 8'h84, 4'h2, 16'h0006},
    '{4'hF, 8'h00, 8'h00, 4'h7, 16'h0000}};
  gpib_card_status_control_regs gpib_card_status_control_regs_i (.clk(clk), .srst(srst),
    .regNum(regNum), .regWr(regWr), .regRd(regRd), .wrData(wrData), .rdData(rdData),
    .intEnable(host[7]), .intLevel(host[6:5]), .dmaEnable(host[4:3]),
    .handshakeBusy(host[2]), .sysController(host[1]), .activeController(host[0]),
    .atnRequest(atnRequest), .busEvent(busEvent), .serialPollPin(serialPollPin),
    .parallelPollPin(parallelPollPin), .dioOut(dioOut), .dioOe(dioOe), .srqOut(srqOut),
    .atnOut(atnOut), .ifReset(ifReset), .intRequest(intRequest));
  bus_controller_model bus_controller_model_i (.clk(clk), .pollCmd(pollCmd), .evtCmd(evtCmd),
    .serialPollPin(serialPollPin), .parallelPollPin(parallelPollPin), .busEvent(busEvent));
  // clock
  always #25 clk = ~clk;
  // compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one register write or read, strobe held for one rising edge
  task automatic acc(input logic wr, input logic [3:0] n, input logic [7:0] d);
    @(negedge clk);
    regNum = n;
    wrData = d;
    regWr  = wr;
    regRd  = !wr;
    @(negedge clk);
    regWr = 1'b0;
    regRd = 1'b0;
  endtask
  // counts and verdict
  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #2000000;
    error_cnt++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    chk("idle outputs", 16'h0, {dioOe, 6'h0, srqOut, atnOut});
    foreach (rows[i]) begin
      host = rows[i].host;
      acc(1'b1, rows[i].wn, rows[i].wd);
      acc(1'b0, rows[i].rn, 8'h00);
      chk("rdData", rows[i].exp, rdData);
    end
    // service request holds, then the byte answers a serial poll
    acc(1'b1, 4'h1, 8'h40);
    repeat (5) @(negedge clk);
    chk("srqOut", 16'h1, {15'h0, srqOut});
    pollCmd = 2'h1;
    repeat (5) @(negedge clk);
    chk("serial dioOut", 16'h40, {8'h00, dioOut});
    chk("serial dioOe", 16'hFF, {8'h00, dioOe});
    // parallel poll byte onto the data lines
    acc(1'b1, 4'h2, 8'hA5);
    pollCmd = 2'h2;
    repeat (5) @(negedge clk);
    chk("parallel dioOut", 16'hA5, {8'h00, dioOut});
    chk("parallel dioOe", 16'hA5, {8'h00, dioOe});
    pollCmd = 2'h0;
    // attention only while active controller
    atnRequest = 1'b1;
    repeat (2) @(negedge clk);
    chk("atnOut idle", 16'h0, {15'h0, atnOut});
    host = 8'h01;
    repeat (2) @(negedge clk);
    chk("atnOut active", 16'h1, {15'h0, atnOut});
    // every event sets its own flag; a read clears the word
    host = 8'h80;
    for (int i = 0; i < 16; i++) begin
      evtCmd = 16'h0001 << i;
      @(negedge clk);
      evtCmd = 16'h0000;
      repeat (5) @(negedge clk);
      chk("intRequest", 16'h1, {15'h0, intRequest});
      acc(1'b0, 4'h4, 8'h00);
      chk("cause", 16'h0001 << i, rdData);
      chk("intRequest cleared", 16'h0, {15'h0, intRequest});
    end
    // zero write keeps state, any set bit resets the interface
    acc(1'b1, 4'h3, 8'h0A);
    acc(1'b1, 4'h0, 8'h00);
    chk("ifReset idle", 16'h0, {15'h0, ifReset});
    acc(1'b0, 4'h3, 8'h00);
    chk("addr kept", 16'h000A, rdData);
    // a pending cause flag must also be cleared by the interface reset
    evtCmd = 16'h0100;
    @(negedge clk);
    evtCmd = 16'h0000;
    repeat (5) @(negedge clk);
    chk("intRequest pending", 16'h1, {15'h0, intRequest});
    acc(1'b1, 4'h0, 8'h01);
    chk("ifReset pulse", 16'h1, {15'h0, ifReset});
    repeat (2) @(negedge clk);
    chk("ifReset ends", 16'h0, {15'h0, ifReset});
    acc(1'b0, 4'h3, 8'h00);
    chk("addr reset", 16'h0000, rdData);
    chk("srqOut reset", 16'h0, {15'h0, srqOut});
    acc(1'b0, 4'h4, 8'h00);
    chk("cause reset", 16'h0000, rdData);
    // synchronous reset in mid-run clears the serial byte and the address
    acc(1'b1, 4'h1, 8'h40);
    acc(1'b1, 4'h3, 8'h15);
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    chk("srqOut after srst", 16'h0, {15'h0, srqOut});
    acc(1'b0, 4'h3, 8'h00);
    chk("addr after srst", 16'h0000, rdData);
    conclude();
  end
endmodule
